// File: src/cpts_cop.sv
// coprocessor end: answers offers and moves data words
`timescale 1ns/1ns
module cpts_cop import cpts_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // link to the processor
  cpts_if.cop bus,
  // coprocessor user side
  input wire logic can_do,
  input wire logic instr_undef,
  input wire logic commit_ok,
  input wire logic [CNT_W-1:0] xfer_words,
  input wire logic [DATA_W-1:0] send_word,
  output logic word_pull,
  output logic recv_we,
  output logic [DATA_W-1:0] recv_word
);
  typedef enum logic {C_IDLE, C_XFER} cpts_cstate_e;

  cpts_cstate_e state_q, state_d;
  cpts_op_e op_q, op_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] recv_q, recv_d;
  logic recv_we_q, recv_we_d;
  logic accept;
  logic last;

  // undefined or unsupported work is never accepted
  assign accept = !bus.coproc_instr_n && can_do && !instr_undef;
  assign last = (cnt_q <= CNT_ONE);

  // next state
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    recv_d = recv_q;
    recv_we_d = 1'b0;
    unique case (state_q)
      C_IDLE: begin
        if (accept && commit_ok) begin
          state_d = C_XFER;
          op_d = bus.instr_kind;
          cnt_d = xfer_words;
        end
      end
      C_XFER: begin
        cnt_d = cnt_q - CNT_ONE;
        if (op_q == OP_TO_COP) begin
          recv_d = bus.coproc_data_word;
          recv_we_d = 1'b1;
        end
        if (op_q != OP_TO_MEM || last) begin
          state_d = C_IDLE;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= C_IDLE;
      op_q <= OP_TO_MEM;
      cnt_q <= '0;
      recv_q <= WORD_RST;
      recv_we_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      recv_q <= recv_d;
      recv_we_q <= recv_we_d;
    end
  end

  // handshake and data drive; lines only ever pull low
  always_comb begin
    bus.absent_oe = 1'b0;
    bus.busy_oe = 1'b0;
    bus.cop_data_oe = 1'b0;
    word_pull = 1'b0;
    unique case (state_q)
      C_IDLE: begin
        bus.absent_oe = accept; // [RULE8] [RULE9] [RULE12]
        bus.busy_oe = accept && commit_ok; // [RULE12]
      end
      C_XFER: begin
        if (op_q != OP_TO_COP) begin
          bus.cop_data_oe = 1'b1;
          word_pull = 1'b1;
        end
        // release on the final word so the lines float high
        if (op_q == OP_TO_MEM && !last) begin
          bus.absent_oe = 1'b1; // [RULE11]
          bus.busy_oe = 1'b1; // [RULE11]
        end
      end
    endcase
  end

  assign bus.absent_out = 1'b0;
  assign bus.busy_out = 1'b0;
  assign bus.cop_data_out = send_word;
  assign recv_we = recv_we_q;
  assign recv_word = recv_q;
endmodule : cpts_cop

// File: src/cpts_core.sv
// processor end: sequences bus cycles of coprocessor operations
`timescale 1ns/1ns
module cpts_core import cpts_pkg::*; #(
  parameter bit MERGE_LOAD = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // link to the coprocessor
  cpts_if.dev bus,
  // operation request
  input wire logic start,
  input wire cpts_op_e op,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic [ADDR_W-1:0] alu_addr,
  input wire logic [DATA_W-1:0] src_word,
  // status and results
  output logic seq_busy,
  output logic done,
  output logic undef_trap,
  output logic dest_we,
  output logic [DATA_W-1:0] dest_word
);
  // offer, wait and transfer phases of one coprocessor operation
  typedef enum logic [2:0] {
    ST_IDLE, ST_OFFER, ST_WAIT, ST_XFER, ST_LOADWR, ST_TRAP
  } cpts_state_e;

  // sequence state, operation kind and operands captured at start
  cpts_state_e state_q, state_d;
  cpts_op_e op_q, op_d;
  logic [ADDR_W-1:0] pc_q, pc_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] word_q, word_d;
  logic done_q, done_d;
  logic trap_q, trap_d;

  // handshake decode; the far end is logic on this same clock
  logic cop_wait;
  logic cop_ready;
  logic cop_decl;
  logic is_mem;
  assign cop_wait = !bus.coproc_absent && bus.coproc_busy;
  assign cop_ready = !bus.coproc_absent && !bus.coproc_busy;
  assign cop_decl = bus.coproc_absent && bus.coproc_busy;
  assign is_mem = (op_q == OP_TO_MEM);

  // sequence next state
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    pc_d = pc_q;
    addr_d = addr_q;
    word_d = word_q;
    done_d = 1'b0;
    trap_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_OFFER;
          op_d = op;
          pc_d = pc;
          addr_d = alu_addr;
          word_d = src_word;
        end
      end
      ST_OFFER, ST_WAIT: begin
        if (cop_decl) begin
          state_d = ST_TRAP; // [RULE10]
        end else if (cop_ready) begin
          state_d = ST_XFER;
        end else if (cop_wait) begin
          state_d = ST_WAIT; // [RULE12]
        end
      end
      ST_XFER: begin
        unique case (op_q)
          OP_TO_MEM: begin
            addr_d = addr_q + WORD_STEP; // [RULE2]
            if (cop_decl) begin
              state_d = ST_IDLE; // [RULE11]
              done_d = 1'b1;
            end
          end
          OP_FROM_COP: begin
            // one sample only, whatever the wait before it
            word_d = bus.coproc_data_word; // [RULE4] [RULE5]
            state_d = ST_LOADWR;
          end
          OP_TO_COP: begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end
          // the unused kind code abandons the operation
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
      // register write cycle, the operation ends after it
      ST_LOADWR: begin
        state_d = ST_IDLE;
        done_d = 1'b1;
      end
      // trap fetch cycle, then the trap pulse
      ST_TRAP: begin
        state_d = ST_IDLE;
        trap_d = 1'b1; // [RULE10]
      end
      // unused state codes fall back to idle
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequence registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      op_q <= OP_TO_MEM;
      pc_q <= ADDR_RST;
      addr_q <= ADDR_RST;
      word_q <= WORD_RST;
      done_q <= 1'b0;
      trap_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      word_q <= word_d;
      done_q <= done_d;
      trap_q <= trap_d;
    end
  end

  // bus cycle signals, decoded from state and handshake
  always_comb begin
    bus.mem_addr = pc_q + PC_NEXT_OFS; // [RULE2]
    bus.mem_write = 1'b0;
    bus.mem_request_n = 1'b1;
    bus.sequential_cycle = 1'b0;
    bus.opcode_fetch_n = 1'b1;
    bus.coproc_instr_n = 1'b1;
    bus.dev_data_oe = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
      end
      ST_OFFER: begin
        // memory cycle only when a memory transfer commits at once
        bus.mem_addr = pc_q + PC_FETCH_OFS; // [RULE1]
        bus.coproc_instr_n = 1'b0; // [RULE1]
        bus.opcode_fetch_n = 1'b0; // [RULE1]
        bus.mem_request_n = !(is_mem && cop_ready);
        bus.sequential_cycle = !is_mem && cop_ready;
      end
      ST_WAIT: begin
        bus.mem_addr = pc_q + PC_FETCH_OFS; // [RULE3]
        bus.coproc_instr_n = 1'b0;
        // request returns in the cycle busy drops
        bus.mem_request_n = !(is_mem && !bus.coproc_busy); // [RULE3]
        bus.sequential_cycle = !is_mem && !bus.coproc_busy;
      end
      ST_XFER: begin
        unique case (op_q)
          OP_TO_MEM: begin
            bus.mem_addr = addr_q; // [RULE1]
            bus.mem_write = 1'b1; // [RULE1]
            bus.mem_request_n = 1'b0;
            bus.sequential_cycle = !cop_decl; // [RULE2]
          end
          OP_FROM_COP: begin
            bus.sequential_cycle = 1'b0; // [RULE5]
          end
          OP_TO_COP: begin
            bus.mem_write = 1'b1; // [RULE7]
            bus.mem_request_n = 1'b0; // [RULE7]
            bus.sequential_cycle = 1'b1; // [RULE7]
            bus.dev_data_oe = 1'b1; // [RULE7]
          end
          default: begin
          end
        endcase
      end
      ST_LOADWR: begin
        bus.mem_request_n = 1'b0; // [RULE5]
        // merged form is one non-sequential memory cycle
        bus.sequential_cycle = !MERGE_LOAD; // [RULE6]
      end
      // trap fetch repeats the offer address, coprocessor line off
      ST_TRAP: begin
        bus.mem_addr = pc_q + PC_FETCH_OFS; // [RULE10]
        bus.mem_request_n = 1'b0;
        bus.opcode_fetch_n = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // data and user-side outputs
  assign bus.dev_data_out = word_q; // [RULE7]
  assign bus.instr_kind = op_q;
  assign seq_busy = (state_q != ST_IDLE);
  assign done = done_q;
  assign undef_trap = trap_q; // [RULE10]
  assign dest_we = (state_q == ST_LOADWR); // [RULE5]
  assign dest_word = word_q;
endmodule : cpts_core

// File: src/cpts_if.sv
// link between the processor end and the coprocessor end
`timescale 1ns/1ns
interface cpts_if;
  import cpts_pkg::*;
  // memory cycle control from the processor
  logic [ADDR_W-1:0] mem_addr;
  logic mem_write;
  logic mem_request_n;
  logic sequential_cycle;
  logic opcode_fetch_n;
  logic coproc_instr_n;
  cpts_op_e instr_kind;
  // shared data bus, one driver per end
  logic [DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  logic [DATA_W-1:0] cop_data_out;
  logic cop_data_oe;
  logic [DATA_W-1:0] coproc_data_word;
  // open-drain handshake lines, pulled high when nobody drives
  logic absent_out;
  logic absent_oe;
  logic busy_out;
  logic busy_oe;
  logic coproc_absent;
  logic coproc_busy;
  // resolved wire levels
  assign coproc_absent = absent_oe ? absent_out : 1'b1;
  assign coproc_busy = busy_oe ? busy_out : 1'b1;
  assign coproc_data_word = dev_data_oe ? dev_data_out :
                            cop_data_oe ? cop_data_out : WORD_RST;
  modport dev (
    output mem_addr, mem_write, mem_request_n, sequential_cycle,
    output opcode_fetch_n, coproc_instr_n, instr_kind,
    output dev_data_out, dev_data_oe,
    input coproc_data_word, coproc_absent, coproc_busy
  );
  modport cop (
    input mem_addr, mem_write, mem_request_n, sequential_cycle,
    input opcode_fetch_n, coproc_instr_n, instr_kind,
    output cop_data_out, cop_data_oe,
    output absent_out, absent_oe, busy_out, busy_oe,
    input coproc_data_word, coproc_absent, coproc_busy
  );
endinterface : cpts_if

// File: src/cpts_pkg.sv
// shared constants and types for the coprocessor transfer sequencer
// Notes on behaviour
// (RULE1) copro-to-memory: fetch PC+8, then write cycles
// (RULE2) step address; last transfer non-sequential, resume PC+12
// (RULE3) busy-wait idles at PC+8 until busy low
// (RULE4) load from coprocessor moves exactly one word
// (RULE5) load samples at PC+12, writes register next
// (RULE6) load write cycle may merge with prefetch
// (RULE7) store drives source word at PC+12, write
// (RULE8) coprocessor unable to execute drives no lines
// (RULE9) undefined instructions are always declined
// (RULE10) both lines high means undefined trap
// (RULE11) coprocessor ends transfer by releasing both lines
// (RULE12) absent low, busy high means wait
package cpts_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  // pc offsets of the fetch, the next fetch and the word step
  localparam logic [ADDR_W-1:0] PC_FETCH_OFS = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] PC_NEXT_OFS = 32'h0000_000C;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  // kind of coprocessor operation offered
  typedef enum logic [1:0] {OP_TO_MEM, OP_FROM_COP, OP_TO_COP} cpts_op_e;
endpackage : cpts_pkg

// File: tb/cpts_checker.sv
// link assertions for the coprocessor transfer sequencer
`timescale 1ns/1ns
module cpts_checker import cpts_pkg::*; #(
  parameter bit MERGE_LOAD = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // link signals
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_write,
  input wire logic mem_request_n,
  input wire logic sequential_cycle,
  input wire logic opcode_fetch_n,
  input wire logic coproc_instr_n,
  input wire cpts_op_e instr_kind,
  input wire logic dev_data_oe,
  input wire logic coproc_absent,
  input wire logic coproc_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [ADDR_W-1:0] fetch_q;
  logic [ADDR_W-1:0] fetch_d;
  logic [ADDR_W-1:0] next_a;
  // offer address kept, pc itself is not on the link
  always_comb begin
    fetch_d = fetch_q;
    if (!coproc_instr_n && !opcode_fetch_n) fetch_d = mem_addr;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) fetch_q <= ADDR_RST;
    else fetch_q <= fetch_d;
  end
  assign next_a = fetch_q + PC_NEXT_OFS - PC_FETCH_OFS;
  // one word cycle of a transfer to memory
  sequence s_xfer;
    instr_kind == OP_TO_MEM && coproc_instr_n && opcode_fetch_n
      && !mem_request_n;
  endsequence
  sequence s_last;
    s_xfer ##0 (coproc_absent && coproc_busy);
  endsequence
  sequence s_load;
    $rose(coproc_instr_n) && opcode_fetch_n && instr_kind == OP_FROM_COP;
  endsequence
  AST_WAIT_QUIET: assert property (!coproc_instr_n && coproc_busy
    |-> mem_request_n && !mem_write) else $error("request while busy");
  AST_WAIT_WAKE: assert property (!coproc_instr_n && opcode_fetch_n
    && !coproc_busy && instr_kind == OP_TO_MEM |-> !mem_request_n)
    else $error("no request when busy fell");
  AST_WAIT_HOLD: assert property (!coproc_instr_n && !coproc_absent
    && coproc_busy |=> !coproc_instr_n && opcode_fetch_n
    && $stable(mem_addr)) else $error("wait not held");
  AST_TRAP: assert property (!coproc_instr_n && coproc_absent
    && coproc_busy |=> coproc_instr_n && !opcode_fetch_n
    && !mem_request_n && mem_addr == fetch_q) else $error("no trap");
  AST_TOMEM_WRITE: assert property (s_xfer |-> mem_write
    && !dev_data_oe) else $error("transfer not a write");
  AST_TOMEM_SEQ: assert property (s_xfer |-> sequential_cycle
    == !(coproc_absent && coproc_busy)) else $error("bad seq flag");
  AST_TOMEM_STEP: assert property (s_xfer ##1 s_xfer
    |-> mem_addr == $past(mem_addr) + WORD_STEP) else $error("no step");
  AST_TOMEM_RESUME: assert property (s_last |=> mem_addr == next_a
    && mem_request_n) else $error("fetch not resumed");
  AST_LOAD: assert property (s_load |-> mem_request_n
    && mem_addr == next_a ##1 !mem_request_n && mem_addr == next_a
    && sequential_cycle != MERGE_LOAD) else $error("bad load cycles");
  AST_STORE: assert property (instr_kind == OP_TO_COP && mem_write
    |-> sequential_cycle && !mem_request_n && dev_data_oe
    && mem_addr == next_a ##1 !mem_write) else $error("bad store cycle");
endmodule : cpts_checker

// File: tb/tb_coprocessor_transfer_sequencer.sv
// bench joining the processor end and the coprocessor end
`timescale 1ns/1ns
module tb_coprocessor_transfer_sequencer;
  import cpts_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  cpts_op_e op = OP_TO_MEM;
  logic [ADDR_W-1:0] pc = ADDR_RST;
  logic [ADDR_W-1:0] alu_addr = ADDR_RST;
  logic [DATA_W-1:0] src_word = WORD_RST;
  logic can_do = 1'b0;
  logic instr_undef = 1'b0;
  logic commit_ok = 1'b0;
  logic [CNT_W-1:0] xfer_words = CNT_ONE;
  logic [DATA_W-1:0] send_word = WORD_RST;
  logic seq_busy, done, undef_trap, dest_we, word_pull, recv_we;
  logic [DATA_W-1:0] dest_word, recv_word;
  int miscompares = 0;
  int n_tests = 0;
  logic [34:0] notes[$];
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  cpts_if i_cpts_if();
  cpts_core #(.MERGE_LOAD(1'b0)) i_cpts_core (
    .clk_sys(clk_sys), .resetn(resetn), .bus(i_cpts_if), .start(start),
    .op(op), .pc(pc), .alu_addr(alu_addr), .src_word(src_word),
    .seq_busy(seq_busy), .done(done), .undef_trap(undef_trap),
    .dest_we(dest_we), .dest_word(dest_word));
  cpts_cop i_cpts_cop (
    .clk_sys(clk_sys), .resetn(resetn), .bus(i_cpts_if), .can_do(can_do),
    .instr_undef(instr_undef), .commit_ok(commit_ok),
    .xfer_words(xfer_words), .send_word(send_word),
    .word_pull(word_pull), .recv_we(recv_we), .recv_word(recv_word));
  cpts_checker #(.MERGE_LOAD(1'b0)) i_cpts_checker (
    .clk_sys(clk_sys), .resetn(resetn),
    .mem_addr(i_cpts_if.mem_addr), .mem_write(i_cpts_if.mem_write),
    .mem_request_n(i_cpts_if.mem_request_n),
    .sequential_cycle(i_cpts_if.sequential_cycle),
    .opcode_fetch_n(i_cpts_if.opcode_fetch_n),
    .coproc_instr_n(i_cpts_if.coproc_instr_n),
    .instr_kind(i_cpts_if.instr_kind),
    .dev_data_oe(i_cpts_if.dev_data_oe),
    .coproc_absent(i_cpts_if.coproc_absent),
    .coproc_busy(i_cpts_if.coproc_busy));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // oldest note against what appeared; empty queue never matches
  task automatic chk(input logic [2:0] kind, input logic [DATA_W-1:0] v);
    logic [34:0] e;
    e = notes.size() > 0 ? notes.pop_front() : '1;
    n_tests++;
    if (e !== {kind, v}) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, e, {kind, v});
    end
  endtask : chk
  // one level against the value it should have
  task automatic chk_lvl(input logic want, input logic got);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, want, got);
    end
  endtask : chk_lvl
  // watcher: same-cycle results taken in a fixed order
  always @(posedge clk_sys) begin
    if (resetn) begin
      if (word_pull === 1'b1) chk(3'h0, i_cpts_if.mem_addr);
      if (dest_we === 1'b1) chk(3'h1, dest_word);
      if (recv_we === 1'b1) chk(3'h2, recv_word);
      if (undef_trap === 1'b1) chk(3'h3, WORD_RST);
      if (done === 1'b1) chk(3'h4, WORD_RST);
      // core busy while words move, idle again in the result cycle
      if (word_pull === 1'b1) chk_lvl(1'b1, seq_busy);
      if (done === 1'b1 || undef_trap === 1'b1)
        chk_lvl(1'b0, seq_busy);
    end
  end
  // one operation; d sets busy-wait and words, mode 1/2 declines
  task automatic run_op(input cpts_op_e k, input int d, input int mode);
    int n;
    logic [ADDR_W-1:0] p;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] s;
    logic [DATA_W-1:0] w;
    n = d < 3 ? 3 - d : 1;
    p = $urandom & 32'hFFFF_FFFC;
    a = $urandom & 32'hFFFF_FFFC;
    s = $urandom;
    w = $urandom;
    pc <= p;
    alu_addr <= a;
    src_word <= s;
    send_word <= w;
    op <= k;
    can_do <= (mode != 1);
    instr_undef <= (mode == 2);
    commit_ok <= (d == 0);
    xfer_words <= CNT_W'(3 - d);
    if (mode != 0) notes.push_back({3'h3, WORD_RST});
    else if (k == OP_TO_MEM) begin
      repeat (n) begin
        notes.push_back({3'h0, a});
        a = a + WORD_STEP;
      end
    end else if (k == OP_FROM_COP) begin
      notes.push_back({3'h0, p + PC_NEXT_OFS});
      notes.push_back({3'h1, w});
    end else notes.push_back({3'h2, s});
    if (mode == 0) notes.push_back({3'h4, WORD_RST});
    start <= 1'b1;
    @(posedge clk_sys);
    if (d == 1) @(posedge clk_sys); // start held while busy is ignored
    start <= 1'b0;
    repeat (d) @(posedge clk_sys);
    commit_ok <= 1'b1;
    for (int t = 0; t < 100 && done !== 1'b1 && undef_trap !== 1'b1; t++)
      @(posedge clk_sys);
    // an operation that never ends is a mismatch, not a silent skip
    if (done !== 1'b1 && undef_trap !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, 1'b1, 1'b0);
    end
  endtask : run_op
  // main sequence
  initial begin
    void'($urandom(32'hC1CE));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int d = 0; d < 4; d++) begin
      run_op(OP_TO_MEM, d, 0);
      run_op(OP_FROM_COP, d, 0);
      run_op(OP_TO_COP, d, 0);
      run_op(cpts_op_e'(d % 3), d % 2, 1);
      run_op(cpts_op_e'(d % 3), d % 2, 2);
    end
    repeat (4) @(posedge clk_sys);
    if (notes.size() != 0) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, 0, notes.size());
    end
    report_and_stop();
  end
  // watchdog: 20 operations need far fewer than 25000 cycles
  initial begin
    #(4 * 25000);
    miscompares++;
    report_and_stop();
  end
endmodule : tb_coprocessor_transfer_sequencer
